// >>> design/splc_pkg.sv
// Purpose: Constants for the self-program lock control block
// Assumes: 64-word pages, 14-bit word address, 200 MHz system clock
// Notes: Control register bit positions follow the store control layout
package splc_pkg;
    // Register offsets and control register bit positions
    localparam logic [1:0] CTRL_ADDR = 2'h0;
    localparam logic [1:0] LOCK_ADDR = 2'h1;
    localparam logic [1:0] PTR_ADDR = 2'h2;
    localparam logic [1:0] DATA_ADDR = 2'h3;
    localparam int SPE_BIT = 0;
    localparam int ERS_BIT = 1;
    localparam int WRT_BIT = 2;
    localparam int LCK_BIT = 3;
    localparam int REN_BIT = 4;
    localparam int BSY_BIT = 6;
    // Accepted low-five-bit command patterns
    localparam logic [4:0] PAT_FILL = 5'h01;
    localparam logic [4:0] PAT_ERASE = 5'h03;
    localparam logic [4:0] PAT_WRITE = 5'h05;
    localparam logic [4:0] PAT_LOCK = 5'h09;
    localparam logic [4:0] PAT_REN = 5'h11;
    // Arming window in clock cycles
    localparam logic [2:0] ARM_CYCLES = 3'h4;
    // Flash operation times
    localparam int FLASH_OP_NS = 4000000;
    localparam int CLK_PERIOD_NS = 5;
    localparam int FLASH_OP_CYC = FLASH_OP_NS / CLK_PERIOD_NS;
    // Lock byte layout and reset value
    localparam logic [7:0] LOCK_RESET = 8'hff;
    localparam int LB_LO = 0;
    localparam int LB_HI = 1;
    localparam int APP_LO = 2;
    localparam int APP_HI = 3;
    localparam int BOOT_LO = 4;
    localparam int BOOT_HI = 5;
    // Address geometry
    localparam int PAGE_WORDS = 64;
    localparam logic [13:0] NO_CONCURRENT_SECTION_START = 14'h3800;
    localparam logic [13:0] BOOT_START = 14'h3800;
    typedef enum logic [1:0] {
        SPLC_IDLE = 2'b00,
        SPLC_ARMED = 2'b01,
        SPLC_BUSY = 2'b10
    } splc_state_e;
endpackage : splc_pkg

// >>> design/splc_top.sv
// Purpose: Self-programming command sequencer with lock-bit enforcement
// Assumes: Core strobes spm_req/lpm_req for one cycle; inputs synchronous
// Notes: Flash array is outside; this block issues erase/write pulses
//
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/10ps
// Function
// [R1] Page write command clears on completion or missed four-cycle window
// [R2] Stall core for whole erase/write when page is in no-concurrent area
// [R3] Erase command plus enable: next store erases pointer page, data ignored
// [R4] Erase command clears on completion or missed four-cycle window
// [R5] Enable permits a store only in the next four cycles
// [R6] Enable alone: store puts data word into page buffer at pointer word
// [R7] Pointer least significant bit ignored for buffer word select
// [R8] Enable clears after store completes or window lapses
// [R9] Enable reads one until erase or write finishes
// [R10] Only five low-bit patterns accepted; others ignored
// [R11] Lock bits active low, bits 7:6 read one, only chip erase restores (reset also loads all ones here)
// [R12] Single-section variant: store allowed everywhere only if fuse is zero
// [R13] Memory lock mode 1 has no restrictions
// [R14] Mode 2 refuses external programming and locks fuses
// [R15] Mode 3 refuses programming, verify, and locks boot locks and fuses
// [R16] Application pair modes 2 and 3 block stores to application
// [R17] Application pair modes 3 and 4 block boot table reads of application
// [R18] App modes 3,4 with boot vectors: no interrupts running application
// [R19] Boot pair modes 2 and 3 block stores to boot section
// [R20] Boot pair modes 3 and 4 block application table reads of boot
// [R21] Boot modes 3,4 with app vectors: no interrupts running boot
// [R22] Programmer should set fuses and boot locks before memory locks
// [R23] Write command plus enable: next store writes buffer to pointer page
// [R24] Lock command plus enable: next store sets lock bits from data low byte
// [R25] Busy set on concurrent-area erase/write; its reads blocked meanwhile
// [R26] Re-enable command plus store clears busy after programming
// [R27] Window counted in clocks from the write; sync clear wipes commands
// [R28] Lock checks combinational from stored byte, code and target section
module splc_top #(
    parameter int FLASH_CYC = splc_pkg::FLASH_OP_CYC
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic sync_clear,
    input wire logic [1:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic spm_req,
    input wire logic lpm_req,
    input wire logic [13:0] exec_addr,
    input wire logic [13:0] lpm_addr,
    input wire logic no_boot_variant,
    input wire logic self_prog_fuse,
    input wire logic vectors_in_boot,
    input wire logic chip_erase,
    output logic cpu_stall,
    output logic lpm_allow,
    output logic irq_block,
    output logic [15:0] buf_wdata,
    output logic [5:0] buf_word,
    output logic buf_we,
    output logic buf_clear,
    output logic [7:0] flash_page,
    output logic flash_erase,
    output logic flash_write,
    output logic concurrent_section_busy,
    output logic ext_prog_block,
    output logic ext_verify_block,
    output logic fuse_locked,
    output logic boot_lock_locked
);
    typedef struct packed {
        splc_pkg::splc_state_e st;
        logic [4:0] cmd;
        logic [2:0] win;
        logic [31:0] cnt;
        logic no_concurrent_section_op;
        logic busy;
        logic [5:0] lock;
        logic [13:0] ptr;
        logic [15:0] data;
        logic [15:0] rdata;
        logic [15:0] bwd;
        logic [5:0] bword;
        logic bwe;
        logic bclr;
        logic [7:0] page;
        logic ers;
        logic wrt;
    } splc_state_s;

    splc_state_s s_q;
    splc_state_s s_d;

    logic store_ok;
    logic tgt_boot;
    logic exe_boot;
    logic lpm_tgt_boot;
    logic [1:0] app_pair;
    logic [1:0] boot_pair;
    logic [7:0] lock_byte;
    logic [7:0] ctrl_view;
    logic spm_on;

    // Lock pair decode
    assign app_pair = {s_q.lock[splc_pkg::APP_HI], s_q.lock[splc_pkg::APP_LO]};
    assign boot_pair = {s_q.lock[splc_pkg::BOOT_HI],
                        s_q.lock[splc_pkg::BOOT_LO]};
    assign lock_byte = {2'b11, s_q.lock}; // [R11]
    assign tgt_boot = (s_q.ptr[13:0] >= splc_pkg::BOOT_START);
    assign exe_boot = (exec_addr >= splc_pkg::BOOT_START);
    assign lpm_tgt_boot = (lpm_addr >= splc_pkg::BOOT_START);
    // Single-section part: the fuse gates every store action except the re-enable store, which clears busy regardless
    assign spm_on = !no_boot_variant || !self_prog_fuse; // [R12]

    // Store permission from lock pairs and variant fuse
    always_comb begin
        if (no_boot_variant) begin
            store_ok = ~self_prog_fuse; // [R12]
        end else if (tgt_boot) begin
            store_ok = boot_pair[0]; // [R19]
        end else begin
            store_ok = app_pair[0]; // [R16]
        end
    end

    // Table read permission, interrupt gating
    always_comb begin
        lpm_allow = 1'b1; // [R28]
        if (concurrent_section_busy && lpm_addr < splc_pkg::NO_CONCURRENT_SECTION_START) begin
            lpm_allow = 1'b0; // [R25]
        end else if (!no_boot_variant && exe_boot && !lpm_tgt_boot
                     && app_pair[1] == 1'b0) begin
            lpm_allow = 1'b0; // [R17]
        end else if (!no_boot_variant && !exe_boot && lpm_tgt_boot
                     && boot_pair[1] == 1'b0) begin
            lpm_allow = 1'b0; // [R20]
        end
        irq_block = 1'b0;
        if (!no_boot_variant && vectors_in_boot && !exe_boot
            && app_pair[1] == 1'b0) begin
            irq_block = 1'b1; // [R18]
        end else if (!no_boot_variant && !vectors_in_boot && exe_boot
                     && boot_pair[1] == 1'b0) begin
            irq_block = 1'b1; // [R21]
        end
    end

    // Memory lock modes for external programming
    assign ext_prog_block = ~s_q.lock[splc_pkg::LB_LO]; // [R13] [R14]
    assign ext_verify_block = ~s_q.lock[splc_pkg::LB_HI]
                              & ~s_q.lock[splc_pkg::LB_LO]; // [R15]
    assign fuse_locked = ~s_q.lock[splc_pkg::LB_LO]; // [R14]
    assign boot_lock_locked = ext_verify_block; // [R15]

    // Control view: enable held during busy operation
    always_comb begin
        ctrl_view = 8'h00;
        ctrl_view[4:0] = s_q.cmd;
        ctrl_view[splc_pkg::SPE_BIT] = s_q.cmd[splc_pkg::SPE_BIT]
            | (s_q.st == splc_pkg::SPLC_BUSY); // [R9]
        ctrl_view[splc_pkg::BSY_BIT] = s_q.busy;
    end

    // Next state
    always_comb begin
        s_d = s_q;
        s_d.bwe = 1'b0;
        s_d.bclr = 1'b0;
        s_d.ers = 1'b0;
        s_d.wrt = 1'b0;
        if (chip_erase) begin
            s_d.lock = 6'h3f; // [R11]
        end
        // Register reads
        s_d.rdata = 16'h0000;
        if (reg_rd) begin
            if (reg_addr == splc_pkg::CTRL_ADDR) begin
                s_d.rdata = {8'h00, ctrl_view};
            end else if (reg_addr == splc_pkg::LOCK_ADDR) begin
                s_d.rdata = {8'h00, lock_byte};
            end else if (reg_addr == splc_pkg::PTR_ADDR) begin
                s_d.rdata = {2'b00, s_q.ptr};
            end else begin
                s_d.rdata = s_q.data;
            end
        end
        // Register writes
        if (reg_wr) begin
            if (reg_addr == splc_pkg::PTR_ADDR) begin
                s_d.ptr = reg_wdata[13:0];
            end else if (reg_addr == splc_pkg::DATA_ADDR) begin
                s_d.data = reg_wdata;
            end else if (reg_addr == splc_pkg::CTRL_ADDR
                         && s_q.st != splc_pkg::SPLC_BUSY) begin
                if (reg_wdata[4:0] == splc_pkg::PAT_FILL
                    || reg_wdata[4:0] == splc_pkg::PAT_ERASE
                    || reg_wdata[4:0] == splc_pkg::PAT_WRITE
                    || reg_wdata[4:0] == splc_pkg::PAT_LOCK
                    || reg_wdata[4:0] == splc_pkg::PAT_REN) begin // [R10]
                    s_d.cmd = reg_wdata[4:0];
                    s_d.win = splc_pkg::ARM_CYCLES; // [R27]
                    s_d.st = splc_pkg::SPLC_ARMED;
                    if (reg_wdata[4:0] == splc_pkg::PAT_REN) begin
                        s_d.bclr = 1'b1; // Re-enable aborts buffer load
                    end
                end
            end
        end
        case (s_q.st)
            splc_pkg::SPLC_IDLE: begin
            end
            splc_pkg::SPLC_ARMED: begin
                if (spm_req) begin // [R5]
                    s_d.cmd = 5'h00; // [R8]
                    s_d.st = splc_pkg::SPLC_IDLE;
                    case (s_q.cmd)
                        splc_pkg::PAT_FILL: begin
                            s_d.bwe = spm_on; // [R6] [R12]
                            s_d.bwd = s_q.data;
                            s_d.bword = s_q.ptr[6:1]; // [R7]
                            s_d.busy = s_q.busy & ~spm_on;
                        end
                        splc_pkg::PAT_ERASE,
                        splc_pkg::PAT_WRITE: begin
                            if (store_ok) begin
                                s_d.page = s_q.ptr[13:6]; // [R3] [R23]
                                s_d.ers = (s_q.cmd == splc_pkg::PAT_ERASE);
                                s_d.wrt = (s_q.cmd == splc_pkg::PAT_WRITE);
                                s_d.cmd = s_q.cmd;
                                s_d.cnt = 32'(FLASH_CYC);
                                s_d.st = splc_pkg::SPLC_BUSY;
                                s_d.no_concurrent_section_op = (s_q.ptr >=
                                               splc_pkg::NO_CONCURRENT_SECTION_START); // [R2]
                                if (s_q.ptr < splc_pkg::NO_CONCURRENT_SECTION_START) begin
                                    s_d.busy = 1'b1; // [R25]
                                end
                            end
                        end
                        splc_pkg::PAT_LOCK: begin
                            s_d.lock = s_d.lock
                                & (spm_on ? s_q.data[5:0] : 6'h3f); // [R24]
                        end
                        default: begin
                            s_d.busy = 1'b0; // [R26]
                        end
                    endcase
                end else if (s_q.win == 3'h1) begin
                    s_d.cmd = 5'h00; // [R1] [R4] [R8]
                    s_d.st = splc_pkg::SPLC_IDLE;
                end
                if (!(reg_wr && reg_addr == splc_pkg::CTRL_ADDR)) begin
                    s_d.win = s_q.win - 3'h1;
                end
            end
            splc_pkg::SPLC_BUSY: begin
                if (s_q.cnt <= 32'h1) begin
                    s_d.cmd = 5'h00; // [R1] [R4]
                    s_d.st = splc_pkg::SPLC_IDLE;
                    s_d.no_concurrent_section_op = 1'b0;
                end else begin
                    s_d.cnt = s_q.cnt - 32'h1;
                end
            end
            default: begin
                s_d.st = splc_pkg::SPLC_IDLE;
            end
        endcase
        if (sync_clear) begin
            s_d.cmd = 5'h00; // [R27]
            s_d.win = 3'h0;
            s_d.st = splc_pkg::SPLC_IDLE;
            s_d.cnt = 32'h0;
            s_d.no_concurrent_section_op = 1'b0;
        end
    end

    // State register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_q <= '0;
            s_q.lock <= splc_pkg::LOCK_RESET[5:0];
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    // Outputs
    assign reg_rdata = s_q.rdata;
    assign cpu_stall = (s_q.st == splc_pkg::SPLC_BUSY) & s_q.no_concurrent_section_op; // [R2]
    assign buf_wdata = s_q.bwd;
    assign buf_word = s_q.bword;
    assign buf_we = s_q.bwe;
    assign buf_clear = s_q.bclr;
    assign flash_page = s_q.page;
    assign flash_erase = s_q.ers;
    assign flash_write = s_q.wrt;
    assign concurrent_section_busy = s_q.busy;

    // Armed state never outlives four cycles free of control register writes
    window_bound_a: assert property (@(posedge clk) disable iff (reset) // [R5]
        clk_en && !(reg_wr && reg_addr == splc_pkg::CTRL_ADDR)
        && s_q.st == splc_pkg::SPLC_ARMED && s_q.win == 3'h1 && !spm_req
        |=> s_q.st == splc_pkg::SPLC_IDLE && s_q.cmd == 5'h00)
        else $error("arming window overran");
    fill_word_a: assert property (@(posedge clk) disable iff (reset) // [R7]
        clk_en && !sync_clear && s_q.st == splc_pkg::SPLC_ARMED && spm_req
        && s_q.cmd == splc_pkg::PAT_FILL && spm_on
        |=> buf_we && buf_word == $past(s_q.ptr[6:1]))
        else $error("buffer fill word wrong");
    enable_held_a: assert property (@(posedge clk) disable iff (reset) // [R9]
        clk_en && reg_rd && reg_addr == splc_pkg::CTRL_ADDR
        && s_q.st == splc_pkg::SPLC_BUSY |=> reg_rdata[splc_pkg::SPE_BIT])
        else $error("enable dropped while busy");
    stall_no_concurrent_section_a: assert property (@(posedge clk) disable iff (reset) // [R2]
        cpu_stall |-> s_q.st == splc_pkg::SPLC_BUSY && s_q.page >= 8'he0)
        else $error("stall outside no-concurrent page");
    lock_mono_a: assert property (@(posedge clk) disable iff (reset) // [R11]
        !chip_erase |=> (s_q.lock & ~$past(s_q.lock)) == 6'h00)
        else $error("lock bit returned to one");
    bad_pattern_a: assert property (@(posedge clk) disable iff (reset) // [R10]
        clk_en && !sync_clear && reg_wr && reg_addr == splc_pkg::CTRL_ADDR
        && s_q.st == splc_pkg::SPLC_IDLE && reg_wdata[0] == 1'b0
        |=> s_q.st == splc_pkg::SPLC_IDLE)
        else $error("illegal pattern armed");
    app_store_a: assert property (@(posedge clk) disable iff (reset) // [R16]
        !no_boot_variant && !tgt_boot && !app_pair[0] |-> !store_ok)
        else $error("application store not blocked");
    boot_read_a: assert property (@(posedge clk) disable iff (reset) // [R20]
        !no_boot_variant && !exe_boot && lpm_tgt_boot && !boot_pair[1]
        |-> !lpm_allow)
        else $error("boot table read not blocked");

    // Stall start, fuse gate, busy-section reads and boot stores
    stall_start_a: assert property (@(posedge clk) disable iff (reset) // [R2]
        clk_en && !sync_clear && s_q.st == splc_pkg::SPLC_ARMED && spm_req
        && (s_q.cmd == splc_pkg::PAT_ERASE || s_q.cmd == splc_pkg::PAT_WRITE)
        && store_ok && s_q.ptr >= splc_pkg::NO_CONCURRENT_SECTION_START |=> cpu_stall)
        else $error("no stall for no-concurrent page");
    fuse_gate_a: assert property (@(posedge clk) disable iff (reset) // [R12]
        clk_en && no_boot_variant && self_prog_fuse
        |=> !buf_we && !flash_erase && !flash_write)
        else $error("store acted with fuse unprogrammed");
    busy_read_a: assert property (@(posedge clk) disable iff (reset) // [R25]
        concurrent_section_busy && lpm_addr < splc_pkg::NO_CONCURRENT_SECTION_START
        |-> !lpm_allow)
        else $error("busy section read allowed");
    boot_store_a: assert property (@(posedge clk) disable iff (reset) // [R19]
        !no_boot_variant && tgt_boot && !boot_pair[0] |-> !store_ok)
        else $error("boot store not blocked");
endmodule : splc_top

// >>> dv/splc_core_model.sv
// Purpose: Core model that issues store-program strobes
// Assumes: Strobe taken at rising clk; core halts while stalled
// Notes: Code and table-read addresses are held levels
`timescale 1ns/10ps
module splc_core_model (
    input wire logic clk,
    input wire logic cpu_stall,
    output logic spm_req,
    output logic [13:0] exec_addr,
    output logic [13:0] lpm_addr
);
    // Idle core at time zero
    initial begin
        spm_req = 1'b0;
        exec_addr = 14'h0000;
        lpm_addr = 14'h0000;
    end
    // Move code and table-read addresses
    task automatic place(input logic [13:0] pc, input logic [13:0] ta);
        @(posedge clk);
        exec_addr <= pc;
        lpm_addr <= ta;
    endtask : place
    // Store after n edges; a halted core waits up to 1000 edges before issuing
    task automatic store(input int n);
        int w;
        w = 0;
        repeat (n) @(posedge clk);
        while (cpu_stall === 1'b1 && w < 1000) begin
            @(posedge clk);
            w++;
        end
        spm_req <= 1'b1;
        @(posedge clk);
        spm_req <= 1'b0;
    endtask : store
endmodule : splc_core_model

// >>> dv/testbench.sv
// Purpose: Self-checking bench for the self-program lock control block
// Assumes: Flash time shortened to 20 cycles
// Notes: Store outputs sampled just after the strobe's edge
`timescale 1ns/10ps
module testbench;
    logic clk, reset, sync_clear, reg_wr, reg_rd, spm_req;
    logic [1:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, buf_wdata, rd;
    logic no_boot_variant, self_prog_fuse, vectors_in_boot, chip_erase;
    logic [13:0] exec_addr, lpm_addr;
    logic cpu_stall, lpm_allow, irq_block, buf_we, buf_clear;
    logic flash_erase, flash_write, concurrent_section_busy;
    logic ext_prog_block, ext_verify_block, fuse_locked, boot_lock_locked;
    logic [5:0] buf_word;
    logic [7:0] flash_page;
    int err_total = 0;
    int n_compared = 0;
    // Block under test and its core
    splc_top #(.FLASH_CYC(20)) dut (.clk, .reset, .clk_en(1'b1),
        .sync_clear, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .spm_req, .lpm_req(1'b0), .exec_addr, .lpm_addr, .no_boot_variant,
        .self_prog_fuse, .vectors_in_boot, .chip_erase, .cpu_stall,
        .lpm_allow, .irq_block, .buf_wdata, .buf_word, .buf_we, .buf_clear,
        .flash_page, .flash_erase, .flash_write, .concurrent_section_busy,
        .ext_prog_block, .ext_verify_block, .fuse_locked, .boot_lock_locked);
    splc_core_model core (.clk, .cpu_stall, .spm_req, .exec_addr, .lpm_addr);
    // Clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic flags(input logic [3:0] e);
        chk({12'h000, ext_prog_block, ext_verify_block, fuse_locked,
            boot_lock_locked}, {12'h000, e});
    endtask : flags
    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rdr(input logic [1:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        rd = reg_rdata;
    endtask : rdr
    // Arm with a pattern, store after n edges, settle
    task automatic go(input logic [4:0] pat, input int n);
        wr(splc_pkg::CTRL_ADDR, {11'h000, pat});
        core.store(n);
        #1;
    endtask : go
    task automatic lockset(input logic [15:0] d);
        wr(splc_pkg::DATA_ADDR, d);
        go(splc_pkg::PAT_LOCK, 1);
    endtask : lockset
    task automatic t_reset;
        rdr(splc_pkg::CTRL_ADDR);
        chk(rd, 16'h0000);
        rdr(splc_pkg::LOCK_ADDR);
        chk(rd, 16'h00ff);
        flags(4'h0);
        $display("reset test done");
    endtask : t_reset
    task automatic t_fill;
        wr(splc_pkg::PTR_ADDR, 16'h0043);
        wr(splc_pkg::DATA_ADDR, 16'ha5c3);
        go(splc_pkg::PAT_FILL, 1);
        chk(16'(buf_we), 16'h0001);
        chk(16'(buf_word), 16'h0021);
        chk(buf_wdata, 16'ha5c3);
        rdr(splc_pkg::CTRL_ADDR);
        chk(rd, 16'h0000);
        rdr(splc_pkg::PTR_ADDR);
        chk(rd, 16'h0043);
        rdr(splc_pkg::DATA_ADDR);
        chk(rd, 16'ha5c3);
        $display("fill test done");
    endtask : t_fill
    task automatic t_erase;
        wr(splc_pkg::PTR_ADDR, 16'h0080);
        go(splc_pkg::PAT_ERASE, 3);
        chk(16'(flash_erase), 16'h0001);
        chk(16'(flash_page), 16'h0002);
        rdr(splc_pkg::CTRL_ADDR);
        chk(rd & 16'h0041, 16'h0041);
        chk(16'(concurrent_section_busy), 16'h0001);
        chk(16'(cpu_stall), 16'h0000);
        repeat (25) @(posedge clk);
        #1;
        chk(16'(lpm_allow), 16'h0000);
        rdr(splc_pkg::CTRL_ADDR);
        chk(rd, 16'h0040);
        // Clear pulse stands only in the cycle after the write
        wr(splc_pkg::CTRL_ADDR, {11'h000, splc_pkg::PAT_REN});
        #1;
        chk(16'(buf_clear), 16'h0001);
        core.store(1);
        #1;
        rdr(splc_pkg::CTRL_ADDR);
        chk(rd, 16'h0000);
        chk(16'(lpm_allow), 16'h0001);
        go(splc_pkg::PAT_WRITE, 4);
        chk(16'(flash_write), 16'h0000);
        rdr(splc_pkg::CTRL_ADDR);
        chk(rd, 16'h0000);
        $display("erase test done");
    endtask : t_erase
    task automatic t_write;
        wr(splc_pkg::PTR_ADDR, 16'h3840);
        go(splc_pkg::PAT_WRITE, 1);
        chk(16'(flash_write), 16'h0001);
        chk(16'(flash_page), 16'h00e1);
        chk(16'(cpu_stall), 16'h0001);
        repeat (25) @(posedge clk);
        #1;
        chk(16'(cpu_stall), 16'h0000);
        rdr(splc_pkg::CTRL_ADDR);
        chk(rd, 16'h0000);
        $display("write test done");
    endtask : t_write
    task automatic t_refuse;
        wr(splc_pkg::CTRL_ADDR, 16'h0007);
        rdr(splc_pkg::CTRL_ADDR);
        chk(rd, 16'h0000);
        core.store(1);
        #1;
        chk({13'h0, buf_we, flash_erase, flash_write}, 16'h0000);
        wr(splc_pkg::CTRL_ADDR, 16'h0001);
        sync_clear <= 1'b1;
        @(posedge clk);
        sync_clear <= 1'b0;
        core.store(0);
        #1;
        chk(16'(buf_we), 16'h0000);
        $display("refuse test done");
    endtask : t_refuse
    // Boot pairs first, memory lock last
    task automatic t_lock;
        core.place(14'h3900, 14'h0100);
        lockset(16'h00e7);
        rdr(splc_pkg::LOCK_ADDR);
        chk(rd, 16'h00e7);
        flags(4'h0);
        chk(16'(lpm_allow), 16'h0000);
        wr(splc_pkg::PTR_ADDR, 16'h3900);
        go(splc_pkg::PAT_ERASE, 1);
        chk(16'(flash_erase), 16'h0000);
        core.place(14'h0100, 14'h3900);
        #1;
        chk(16'(lpm_allow), 16'h0001);
        chk(16'(irq_block), 16'h0001);
        lockset(16'h00e6);
        flags(4'ha);
        lockset(16'h0000);
        rdr(splc_pkg::LOCK_ADDR);
        chk(rd, 16'h00c0);
        flags(4'hf);
        chk(16'(lpm_allow), 16'h0000);
        core.place(14'h3900, 14'h0100);
        vectors_in_boot <= 1'b0;
        wr(splc_pkg::PTR_ADDR, 16'h0100);
        go(splc_pkg::PAT_ERASE, 1);
        chk(16'(flash_erase), 16'h0000);
        chk(16'(irq_block), 16'h0001);
        @(posedge clk);
        chip_erase <= 1'b1;
        @(posedge clk);
        chip_erase <= 1'b0;
        rdr(splc_pkg::LOCK_ADDR);
        chk(rd, 16'h00ff);
        flags(4'h0);
        $display("lock test done");
    endtask : t_lock
    task automatic t_single;
        @(posedge clk);
        no_boot_variant <= 1'b1;
        go(splc_pkg::PAT_FILL, 1);
        chk(16'(buf_we), 16'h0000);
        @(posedge clk);
        self_prog_fuse <= 1'b0;
        go(splc_pkg::PAT_FILL, 1);
        chk(16'(buf_we), 16'h0001);
        $display("single section test done");
    endtask : t_single
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up
    // Watchdog
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        wrap_up();
    end
    // Main sequence
    initial begin
        reset = 1'b1;
        {sync_clear, reg_wr, reg_rd, chip_erase, no_boot_variant} = 5'h00;
        reg_addr = 2'h0;
        reg_wdata = 16'h0000;
        self_prog_fuse = 1'b1;
        vectors_in_boot = 1'b1;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        t_reset();
        t_fill();
        t_erase();
        t_write();
        t_refuse();
        t_lock();
        t_single();
        wrap_up();
    end
endmodule : testbench
